//--- rtl/hpm_defs.svh
// Notes on behaviour
// - Lock timing to a present 2.048 MHz reference
// - Line clock 2048 kHz, forced high on LOS
// - Highway rate 4096 or 2048 kbit/s by select
// - At 4096, drive data only in chosen phase
// - Launch receive data on receive clock falling edge
// - Receive offset fields set sync-to-timeslot-0 delay
// - Frame pulse low 488 ns, suppressed on LFA
// - CAS freeze shows CAS async state on pulse pin
// - Mark enabled receive Sa bits in NFAS frames
// - Mark enabled transmit Sa bits in NFAS frames
// - Transmit signaling marker on selected timeslots, phase
// - Receive signaling marker on selected timeslots, phase
// - Sample receive sync on receive clock falling edges
// - Sample transmit sync on transmit clock falling edges
// - Latch transmit data on transmit clock falling edges
// - At 4096, sample transmit data in chosen phase
// - Multiframe begin marks first bit of frame 1
`ifndef HPM_DEFS_SVH
`define HPM_DEFS_SVH

// ==========================================================
// Timing
`define HPM_CLK_MHZ        50
`define HPM_SCLK_KHZ       8192
`define HPM_FRAME_US       125
`define HPM_REF_KHZ        2048
`define HPM_PULSE_NS       488

// ==========================================================
// Register byte addresses
`define HPM_ADDR_CTRL      8'h00
`define HPM_ADDR_RX_OFS    8'h04
`define HPM_ADDR_TX_OFS    8'h08
`define HPM_ADDR_RX_TSSEL  8'h0C
`define HPM_ADDR_TX_TSSEL  8'h10
`define HPM_ADDR_STATUS    8'h14

// ==========================================================
// Field positions and reset values
`define HPM_CTRL_RATE      0
`define HPM_CTRL_PHASE     1
`define HPM_CTRL_ELOS      2
`define HPM_CTRL_CFRZ      3
`define HPM_CTRL_SAE_LSB   4
`define HPM_CTRL_SAE_MSB   8
`define HPM_OFS_TS_LSB     0
`define HPM_OFS_TS_MSB     5
`define HPM_OFS_CS_LSB     6
`define HPM_OFS_CS_MSB     8
`define HPM_OFS_FINE       9
`define HPM_SA_FIRST_BIT   3'h3
`define HPM_CTRL_RST       9'h000
`define HPM_OFS_RST        10'h000
`define HPM_TSSEL_RST      32'h0000_0000

`endif

//--- rtl/hpm_pkg.sv
`include "hpm_defs.svh"

package hpm_pkg;
  typedef logic [9:0] hpm_pos_t;
  typedef logic [7:0] hpm_byte_t;
  typedef logic [9:0] hpm_ofs_t;
  typedef enum logic {
    HPM_RATE_2048,
    HPM_RATE_4096
  } hpm_rate_e;
endpackage

//--- rtl/hpm_frame_mem.sv
`timescale 1ns/100ps
`default_nettype none

module hpm_frame_mem
  import hpm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [4:0] wr_addr,
  input  wire hpm_byte_t  wr_data,
  input  wire logic [4:0] rd_addr,
  output hpm_byte_t       rd_data
);

  // ========================================================
  // Storage, one byte per timeslot
  hpm_byte_t mem [32];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

`default_nettype wire

//--- rtl/hpm_highway_port.sv
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "hpm_defs.svh"

module hpm_highway_port
  import hpm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sync_ref_clock,
  input  wire logic        rx_system_clock,
  input  wire logic        tx_system_clock,
  input  wire logic        rx_sync_pulse_n,
  input  wire logic        tx_sync_pulse_n,
  input  wire logic        tx_highway_data,
  input  wire logic        line_wr_en,
  input  wire logic [4:0]  line_wr_addr,
  input  wire hpm_byte_t   line_wr_data,
  input  wire logic        loss_of_signal_flag,
  input  wire logic        loss_of_frame_align_flag,
  input  wire logic        cas_controller_async,
  input  wire logic        rx_fas_frame,
  input  wire logic        rx_mf_first_frame,
  output logic             recovered_line_clock,
  output logic             rx_highway_data,
  output logic             rx_highway_data_oe,
  output logic             rx_frame_pulse_n,
  output logic             rx_multiframe_begin,
  output logic             rx_signaling_marker,
  output logic             rx_spare_bit_marker,
  output logic             tx_signaling_marker,
  output logic             tx_spare_bit_marker,
  output logic             tx_byte_valid,
  output hpm_byte_t        tx_byte,
  output logic [4:0]       tx_byte_slot
);

  // ========================================================
  // Derived counts
  localparam int SCLK_PER_FRAME =
    `HPM_SCLK_KHZ * `HPM_FRAME_US / 1000;
  localparam int PULSE_SCLK =
    (`HPM_PULSE_NS * `HPM_SCLK_KHZ + 999_999) / 1_000_000;
  // Two reference periods without an edge means no reference
  localparam int REF_TMO_CYC =
    2 * 1_000_000 * `HPM_CLK_MHZ / (`HPM_REF_KHZ * 1000);
  localparam hpm_pos_t POS_LAST = 10'(SCLK_PER_FRAME - 1);
  localparam hpm_pos_t PULSE_END = 10'(PULSE_SCLK);
  localparam logic [7:0] REF_TMO = 8'(REF_TMO_CYC);

  // ========================================================
  // Registers
  logic [8:0]  ctrl_ff;
  hpm_ofs_t    rx_ofs_ff;
  hpm_ofs_t    tx_ofs_ff;
  logic [31:0] rx_tssel_ff;
  logic [31:0] tx_tssel_ff;
  logic        rx_synced_ff;
  logic        tx_synced_ff;
  logic        ref_present_ff;

  hpm_rate_e   rate;
  logic        phase_sel;
  logic        elos;
  logic        cfrz;
  logic [4:0]  sa_en;

  assign rate      = hpm_rate_e'(ctrl_ff[`HPM_CTRL_RATE]);
  assign phase_sel = ctrl_ff[`HPM_CTRL_PHASE];
  assign elos      = ctrl_ff[`HPM_CTRL_ELOS];
  assign cfrz      = ctrl_ff[`HPM_CTRL_CFRZ];
  assign sa_en     = ctrl_ff[`HPM_CTRL_SAE_MSB:`HPM_CTRL_SAE_LSB];

  // ========================================================
  // APB slave, zero wait states, registered answer
  logic        apb_setup;
  logic        apb_wr;
  logic        addr_ok;
  logic [31:0] nxt_rdata;
  logic [31:0] status_word;

  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready && pwrite;
  assign status_word = {26'h000_0000, tx_synced_ff, rx_synced_ff,
                        ref_present_ff, cas_controller_async,
                        loss_of_frame_align_flag, loss_of_signal_flag};

  always_comb begin
    addr_ok   = 1'b1;
    nxt_rdata = 32'h0000_0000;
    unique case (paddr)
      `HPM_ADDR_CTRL:     nxt_rdata = {23'h00_0000, ctrl_ff};
      `HPM_ADDR_RX_OFS:   nxt_rdata = {22'h00_0000, rx_ofs_ff};
      `HPM_ADDR_TX_OFS:   nxt_rdata = {22'h00_0000, tx_ofs_ff};
      `HPM_ADDR_RX_TSSEL: nxt_rdata = rx_tssel_ff;
      `HPM_ADDR_TX_TSSEL: nxt_rdata = tx_tssel_ff;
      `HPM_ADDR_STATUS:   nxt_rdata = status_word;
      default:            addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        prdata  <= pwrite ? 32'h0000_0000 : nxt_rdata;
        pslverr <= !addr_ok;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff     <= `HPM_CTRL_RST;
      rx_ofs_ff   <= `HPM_OFS_RST;
      tx_ofs_ff   <= `HPM_OFS_RST;
      rx_tssel_ff <= `HPM_TSSEL_RST;
      tx_tssel_ff <= `HPM_TSSEL_RST;
    end else if (apb_wr) begin
      unique case (paddr)
        `HPM_ADDR_CTRL:     ctrl_ff     <= pwdata[8:0];
        `HPM_ADDR_RX_OFS:   rx_ofs_ff   <= pwdata[9:0];
        `HPM_ADDR_TX_OFS:   tx_ofs_ff   <= pwdata[9:0];
        `HPM_ADDR_RX_TSSEL: rx_tssel_ff <= pwdata;
        `HPM_ADDR_TX_TSSEL: tx_tssel_ff <= pwdata;
        default: ;
      endcase
    end
  end

  // ========================================================
  // Pin synchronisers; stage 1 feeds only stage 2
  logic [5:0] pin_s1_ff;
  logic [5:0] pin_s2_ff;
  logic [2:0] pin_s3_ff;
  logic       rx_fall_ev;
  logic       tx_fall_ev;
  logic       ref_rise_ev;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Idle pin levels, so no false reference edge follows reset
      pin_s1_ff <= 6'h38;
      pin_s2_ff <= 6'h38;
      pin_s3_ff <= 3'h0;
    end else begin
      pin_s1_ff <= {tx_sync_pulse_n, rx_sync_pulse_n, tx_highway_data,
                    sync_ref_clock, tx_system_clock, rx_system_clock};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff[2:0];
    end
  end

  assign rx_fall_ev  = pin_s3_ff[0] && !pin_s2_ff[0];
  assign tx_fall_ev  = pin_s3_ff[1] && !pin_s2_ff[1];
  assign ref_rise_ev = !pin_s3_ff[2] && pin_s2_ff[2];

  // ========================================================
  // Reference clock presence
  logic [7:0] ref_cnt_ff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt_ff     <= REF_TMO;
      ref_present_ff <= 1'b0;
    end else begin
      if (ref_rise_ev) begin
        ref_cnt_ff <= 8'h00;
      end else if (ref_cnt_ff != REF_TMO) begin
        ref_cnt_ff <= ref_cnt_ff + 8'h01;
      end
      ref_present_ff <= ref_cnt_ff != REF_TMO;
    end
  end

  // ========================================================
  // Frame position counters, one count per system clock
  function automatic hpm_pos_t ofs_load(input hpm_ofs_t ofs);
    logic [10:0] dly;
    dly = {ofs[`HPM_OFS_TS_MSB:`HPM_OFS_TS_LSB], 5'h00}
        + {6'h00, ofs[`HPM_OFS_CS_MSB:`HPM_OFS_CS_LSB], 2'h0}
        + {9'h000, ofs[`HPM_OFS_FINE], 1'b0};
    return 10'(11'h000 - dly);
  endfunction

  hpm_pos_t rx_pos_ff;
  hpm_pos_t tx_pos_ff;
  logic     rx_syncprev_ff;
  logic     tx_syncprev_ff;
  logic     rx_sync_start;
  logic     tx_sync_start;
  hpm_pos_t rx_load;
  hpm_pos_t tx_load;

  assign rx_sync_start = rx_syncprev_ff && !pin_s2_ff[4];
  assign tx_sync_start = tx_syncprev_ff && !pin_s2_ff[5];
  assign rx_load = ofs_load(rx_ofs_ff);
  assign tx_load = ofs_load(tx_ofs_ff);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_pos_ff      <= 10'h000;
      rx_syncprev_ff <= 1'b1;
      rx_synced_ff   <= 1'b0;
    end else if (rx_fall_ev) begin
      rx_syncprev_ff <= pin_s2_ff[4];
      if (rx_sync_start) begin
        rx_pos_ff    <= rx_load;
        rx_synced_ff <= 1'b1;
      end else begin
        rx_pos_ff <= (rx_pos_ff == POS_LAST) ? 10'h000
                   : rx_pos_ff + 10'h001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pos_ff      <= 10'h000;
      tx_syncprev_ff <= 1'b1;
      tx_synced_ff   <= 1'b0;
    end else if (tx_fall_ev) begin
      tx_syncprev_ff <= pin_s2_ff[5];
      if (tx_sync_start) begin
        tx_pos_ff    <= tx_load;
        tx_synced_ff <= 1'b1;
      end else begin
        tx_pos_ff <= (tx_pos_ff == POS_LAST) ? 10'h000
                   : tx_pos_ff + 10'h001;
      end
    end
  end

  // ========================================================
  // Receive highway
  hpm_byte_t  rx_slot_byte;
  logic [4:0] rx_ts;
  logic [2:0] rx_bit;
  logic       rx_in_phase;
  logic       rx_sa_bit;

  assign rx_ts  = rx_pos_ff[9:5];
  assign rx_bit = rx_pos_ff[4:2];
  // Each 2048 bit cell is four clocks; 4096 phases are its halves
  assign rx_in_phase = (rate == HPM_RATE_2048)
                    || (rx_pos_ff[1] == phase_sel);
  assign rx_sa_bit = (rx_ts == 5'h00) && (rx_bit >= `HPM_SA_FIRST_BIT)
                  && sa_en[3'(rx_bit - `HPM_SA_FIRST_BIT)];

  hpm_frame_mem u_rx_mem (
    .clk     (ref_clk),
    .rst_n   (rst_n),
    .wr_en   (line_wr_en),
    .wr_addr (line_wr_addr),
    .wr_data (line_wr_data),
    .rd_addr (rx_ts),
    .rd_data (rx_slot_byte)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_highway_data     <= 1'b1;
      rx_highway_data_oe  <= 1'b0;
      rx_signaling_marker <= 1'b0;
      rx_spare_bit_marker <= 1'b0;
      rx_multiframe_begin <= 1'b0;
      rx_frame_pulse_n    <= 1'b1;
    end else if (rx_fall_ev) begin
      rx_highway_data     <= rx_slot_byte[3'h7 - rx_bit];
      rx_highway_data_oe  <= rx_synced_ff && rx_in_phase;
      rx_signaling_marker <= rx_tssel_ff[rx_ts] && rx_in_phase;
      rx_spare_bit_marker <= rx_sa_bit && !rx_fas_frame;
      // Same four clocks at either rate: one 2048 bit, two 4096 bits
      rx_multiframe_begin <= rx_mf_first_frame
                          && (rx_pos_ff[9:2] == 8'h00);
      if (cfrz) begin
        rx_frame_pulse_n <= cas_controller_async;
      end else begin
        rx_frame_pulse_n <= loss_of_frame_align_flag
                         || (rx_pos_ff >= PULSE_END);
      end
    end
  end

  // ========================================================
  // Recovered line clock
  // Without a reference the clock follows the receive bit grid
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      recovered_line_clock <= 1'b1;
    end else if (elos && loss_of_signal_flag) begin
      recovered_line_clock <= 1'b1;
    end else if (ref_present_ff) begin
      recovered_line_clock <= pin_s2_ff[2];
    end else begin
      recovered_line_clock <= !rx_pos_ff[1];
    end
  end

  // ========================================================
  // Transmit highway
  logic [4:0] tx_ts;
  logic [2:0] tx_bit;
  logic [1:0] tx_sample_idx;
  logic       tx_sample_ev;
  logic       tx_in_phase;
  logic       tx_nfas_ff;
  logic [6:0] tx_shift_ff;
  logic       tx_sa_bit;

  assign tx_ts  = tx_pos_ff[9:5];
  assign tx_bit = tx_pos_ff[4:2];
  // Sample in the middle of the cell to stay clear of the launch edge
  assign tx_sample_idx = (rate == HPM_RATE_2048) ? 2'h2
                       : (phase_sel ? 2'h3 : 2'h1);
  assign tx_sample_ev = tx_fall_ev && tx_synced_ff
                     && (tx_pos_ff[1:0] == tx_sample_idx);
  assign tx_in_phase = (rate == HPM_RATE_2048)
                    || (tx_pos_ff[1] == phase_sel);
  assign tx_sa_bit = (tx_ts == 5'h00) && (tx_bit >= `HPM_SA_FIRST_BIT)
                  && sa_en[3'(tx_bit - `HPM_SA_FIRST_BIT)];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_nfas_ff <= 1'b0;
    // A sync that lands on the running grid keeps the frame parity
    end else if (tx_fall_ev && tx_sync_start
                 && tx_pos_ff + 10'h001 != tx_load) begin
      tx_nfas_ff <= 1'b0;
    end else if (tx_fall_ev && tx_pos_ff == POS_LAST) begin
      tx_nfas_ff <= !tx_nfas_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_signaling_marker <= 1'b0;
      tx_spare_bit_marker <= 1'b0;
    end else if (tx_fall_ev) begin
      tx_signaling_marker <= tx_tssel_ff[tx_ts] && tx_in_phase;
      tx_spare_bit_marker <= tx_sa_bit && tx_nfas_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift_ff   <= 7'h00;
      tx_byte_valid <= 1'b0;
      tx_byte       <= 8'h00;
      tx_byte_slot  <= 5'h00;
    end else begin
      tx_byte_valid <= 1'b0;
      if (tx_sample_ev) begin
        tx_shift_ff <= {tx_shift_ff[5:0], pin_s2_ff[3]};
        if (tx_bit == 3'h7) begin
          tx_byte_valid <= 1'b1;
          tx_byte       <= {tx_shift_ff, pin_s2_ff[3]};
          tx_byte_slot  <= tx_ts;
        end
      end
    end
  end

  // ========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_line_clk_forced: assert property (
    elos && loss_of_signal_flag |=> recovered_line_clock)
    else $error("line clock not held high on loss of signal");

  a_rx_oe_phase: assert property (
    rx_fall_ev && rate == HPM_RATE_4096 && rx_pos_ff[1] != phase_sel
    |=> !rx_highway_data_oe)
    else $error("receive data driven in wrong channel phase");

  a_rx_launch_edge: assert property (
    !$past(rx_fall_ev) |-> $stable(rx_highway_data))
    else $error("receive data changed away from clock fall");

  a_rx_sync_load: assert property (
    rx_fall_ev && rx_sync_start |=> rx_pos_ff == $past(rx_load))
    else $error("receive offset not loaded on sync");

  a_tx_sync_load: assert property (
    tx_fall_ev && tx_sync_start |=> tx_pos_ff == $past(tx_load))
    else $error("transmit offset not loaded on sync");

  a_pulse_lfa_off: assert property (
    rx_fall_ev && loss_of_frame_align_flag && !cfrz
    |=> rx_frame_pulse_n)
    else $error("frame pulse not suppressed during LFA");

  a_cas_freeze_out: assert property (
    rx_fall_ev && cfrz
    |=> rx_frame_pulse_n == $past(cas_controller_async))
    else $error("CAS state not shown on frame pulse pin");

  a_rsig_unselected: assert property (
    rx_fall_ev && !rx_tssel_ff[rx_ts] |=> !rx_signaling_marker)
    else $error("receive marker on unselected timeslot");

  sequence s_mf_first_cell;
    rx_fall_ev && rx_mf_first_frame && rx_pos_ff[9:2] == 8'h00;
  endsequence

  a_mfb_first_bit: assert property (
    s_mf_first_cell |=> rx_multiframe_begin)
    else $error("multiframe begin missing at frame 1 start");

  a_rx_pos_step: assert property (
    rx_fall_ev && !rx_sync_start && rx_pos_ff != POS_LAST
    |=> rx_pos_ff == $past(rx_pos_ff) + 10'h001)
    else $error("receive position did not advance");

  sequence s_tx_last_sample;
    tx_sample_ev && tx_bit == 3'h7;
  endsequence

  a_tx_byte_done: assert property (
    s_tx_last_sample |=> tx_byte_valid ##1 !tx_byte_valid)
    else $error("transmit byte not delivered after eighth bit");

endmodule

`default_nettype wire

//--- sim/hpm_partner.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Highway partner: system clocks, sync pulses, transmit data
module hpm_partner (
  input  wire logic ref_en,
  output logic      sys_clk,
  output logic      sync_n,
  output logic      tx_data,
  output logic      ref_out
);
  logic [9:0] cnt;
  logic [7:0] pat;

  // One source feeds both system clocks so the two frames stay aligned
  initial begin
    sys_clk = 1'b1;
    #7;
    forever #80 sys_clk = ~sys_clk;
  end

  initial ref_out = 1'b0;
  always #244 ref_out = ref_en & ~ref_out;

  initial begin
    cnt = 10'h000;
    sync_n = 1'b1;
    tx_data = 1'b0;
  end

  assign pat = {3'b110, cnt[9:5]};

  // Lines move on rising edges, well clear of the sampling fall
  always @(posedge sys_clk) begin
    sync_n  <= (cnt != 10'h000);
    tx_data <= pat[3'h7 - cnt[4:2]];
    cnt     <= cnt + 10'h001;
  end
endmodule

`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Highway port bench
module tb_top;
  import hpm_pkg::*;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        sclk, sync_n, txd, refo, ref_en, lw_en, los, lfa, cas;
  logic [4:0]  lw_addr, ts;
  hpm_byte_t   lw_data, tb;
  logic        rlc, rxd, rxoe, fp, mfb, rsig, rspr, xsig, xspr, tv, e, ok;
  logic        fas, mff;
  logic [7:0]  exb;
  int          error_cnt, checks_done, i;
  time         t0, t1;

  hpm_partner i_far (.ref_en(ref_en), .sys_clk(sclk), .sync_n(sync_n),
                     .tx_data(txd), .ref_out(refo));

  hpm_highway_port i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sync_ref_clock(refo),
    .rx_system_clock(sclk), .tx_system_clock(sclk),
    .rx_sync_pulse_n(sync_n), .tx_sync_pulse_n(sync_n),
    .tx_highway_data(txd), .line_wr_en(lw_en), .line_wr_addr(lw_addr),
    .line_wr_data(lw_data), .loss_of_signal_flag(los),
    .loss_of_frame_align_flag(lfa), .cas_controller_async(cas),
    .rx_fas_frame(fas), .rx_mf_first_frame(mff),
    .recovered_line_clock(rlc), .rx_highway_data(rxd),
    .rx_highway_data_oe(rxoe), .rx_frame_pulse_n(fp),
    .rx_multiframe_begin(mfb), .rx_signaling_marker(rsig),
    .rx_spare_bit_marker(rspr), .tx_signaling_marker(xsig),
    .tx_spare_bit_marker(xspr), .tx_byte_valid(tv), .tx_byte(tb),
    .tx_byte_slot(ts));

  always #10 ref_clk = ~ref_clk;

  // ==========================================================
  // Tasks
  task automatic conclude;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic stop;
    error_cnt++;
    $display("mismatch wait expected event got timeout");
    conclude();
  endtask

  task automatic chk_w(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic chk_b(input string nm, input logic ex, input logic got);
    chk_w(nm, {31'h0, ex}, {31'h0, got});
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Request is held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) stop();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_fp;
    int n;
    n = 0;
    while (fp !== 1'b1 && n < 17000) begin
      @(posedge ref_clk);
      n++;
    end
    while (fp !== 1'b0 && n < 17000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 17000) stop();
  endtask

  task automatic wait_tx(input logic [4:0] s);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!(tv === 1'b1 && ts === s) && n < 17000);
    if (n >= 17000) stop();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {ref_clk, rst_n, psel, penable, pwrite, ref_en} = 6'h00;
    {lw_en, los, lfa, cas, fas} = 5'h00;
    mff = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    lw_addr = 5'h00;
    lw_data = 8'h00;
    error_cnt = 0;
    checks_done = 0;
    step(3);
    rst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk_w("ctrl reset", 32'h0000_0000, q);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk_b("unmapped err", 1'b1, e);
    chk_w("unmapped data", 32'h0000_0000, q);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk_b("ref absent", 1'b0, q[3]);
    ref_en <= 1'b1;
    step(200);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk_b("ref present", 1'b1, q[3]);
    apb(1'b1, 8'h00, 32'h0000_01F0);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk_w("ctrl", 32'h0000_01F0, q);
    apb(1'b1, 8'h0C, 32'h0000_0004);
    apb(1'b1, 8'h10, 32'h0000_0004);
    for (i = 0; i < 32; i++) begin
      @(posedge ref_clk);
      lw_en <= 1'b1;
      lw_addr <= i[4:0];
      lw_data <= i[7:0] ^ 8'hA5;
    end
    @(posedge ref_clk);
    lw_en <= 1'b0;
    // Walk through the first timeslots of one receive frame
    exb = 8'hA5;
    wait_fp();
    t0 = $time;
    step(16);
    chk_b("mf begin", 1'b1, mfb);
    chk_b("rx oe", 1'b1, rxoe);
    chk_b("rx bit", exb[7], rxd);
    step(14);
    chk_b("pulse low", 1'b0, fp);
    step(4);
    chk_b("pulse end", 1'b1, fp);
    for (i = 1; i < 8; i++) begin
      step(i == 1 ? 14 : 32);
      chk_b("rx bit", exb[7-i], rxd);
      if (i == 1) chk_b("mf end", 1'b0, mfb);
      if (i == 2) chk_b("spare off", 1'b0, rspr);
      if (i == 3) chk_b("spare on", 1'b1, rspr);
      if (i == 3) ok = xspr;
    end
    step(32);
    chk_b("rx sig off", 1'b0, rsig);
    chk_b("tx sig off", 1'b0, xsig);
    step(256);
    chk_b("rx sig on", 1'b1, rsig);
    chk_b("tx sig on", 1'b1, xsig);
    wait_tx(5'h03);
    chk_w("tx byte", 32'h0000_00C3, {24'h0, tb});
    // Next frame: Sa4 slot again, transmit parity must flip
    wait_fp();
    step(112);
    chk_b("tx spare", ~ok, xspr);
    fas <= 1'b1;
    step(9);
    chk_b("spare fas", 1'b0, rspr);
    fas <= 1'b0;
    apb(1'b1, 8'h08, 32'h0000_0001);
    wait_tx(5'h00);
    wait_tx(5'h00);
    chk_w("tx offset", 32'h0000_00C1, {24'h0, tb});
    // Offset of 1 slot, 1 clockslot and fine step is 38 system clocks
    apb(1'b1, 8'h04, 32'h0000_0241);
    wait_fp();
    wait_fp();
    t1 = $time;
    chk_w("rx offset", 32'd6080, 32'((t1 - t0) % 163840));
    lfa <= 1'b1;
    step(8);
    ok = 1'b1;
    repeat (8300) begin
      @(posedge ref_clk);
      if (fp !== 1'b1) ok = 1'b0;
    end
    chk_b("pulse on lfa", 1'b1, ok);
    lfa <= 1'b0;
    apb(1'b1, 8'h00, 32'h0000_0008);
    cas <= 1'b1;
    step(9);
    chk_b("cas async", 1'b1, fp);
    cas <= 1'b0;
    step(9);
    chk_b("cas sync", 1'b0, fp);
    apb(1'b1, 8'h00, 32'h0000_0004);
    los <= 1'b1;
    step(4);
    ok = 1'b1;
    repeat (40) begin
      @(posedge ref_clk);
      if (rlc !== 1'b1) ok = 1'b0;
    end
    chk_b("clock forced", 1'b1, ok);
    los <= 1'b0;
    step(4);
    i = 0;
    repeat (50) begin
      ok = rlc;
      @(posedge ref_clk);
      if (rlc !== ok) i++;
    end
    chk_b("clock runs", 1'b1, i >= 3);
    for (i = 0; i < 2; i++) begin
      mff <= ~i[0];
      apb(1'b1, 8'h00, {30'h0, i[0], 1'b1});
      wait_fp();
      step(4);
      chk_b("oe phase a", ~i[0], rxoe);
      chk_b("mf 4096", ~i[0], mfb);
      step(16);
      chk_b("oe phase b", i[0], rxoe);
    end
    conclude();
  end
endmodule

`default_nettype wire
